// ### verilog/ast_pkg.sv
package ast_pkg;
  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SEL0 = 8'h04;
  localparam logic [7:0] ADDR_SEL1 = 8'h08;
  localparam logic [7:0] ADDR_SEL2 = 8'h0C;
  localparam logic [7:0] ADDR_PROT = 8'h10;
  localparam logic [7:0] ADDR_MON = 8'h14;
  // ****************************************************************
  // Control and protection register fields
  // ****************************************************************
  localparam int CTRL_START = 0;
  localparam int CTRL_DEPTH = 1;
  localparam int CTRL_SINGLE = 2;
  localparam int CTRL_MEASURE = 3;
  localparam int CTRL_STATUS = 4;
  localparam int PROT_WDG_OFF = 0;
  localparam int PROT_ERR_OFF = 1;
  localparam logic [7:0] PROT_KEY = 8'hA5;
  localparam int PROT_KEY_LSB = 8;
  // Comparator membership per bank, shutdown path and interrupt
  localparam logic [7:0] SS_MASK0 = 8'h2F;
  localparam logic [7:0] SS_MASK1 = 8'h0E;
  localparam logic [7:0] SS_MASK2 = 8'hC9;
  localparam logic [7:0] INT_MASK0 = 8'hD0;
  localparam logic [7:0] INT_MASK1 = 8'hF1;
  localparam logic [7:0] INT_MASK2 = 8'h30;
  // Internal supply overvoltage: bank 2 bit 3
  localparam int INTERNAL_SUPPLY_OVER_SEL_BIT = 19;
  localparam logic [23:0] SEL_RESET = 24'h000000;
  localparam logic [4:0] NUM_CMP = 5'h18;
  // ****************************************************************
  // Timing: stimulus shorter or longer than the deglitch time
  // ****************************************************************
  localparam int CLK_NS = 40;
  localparam int SHORT_NS = 400;
  localparam int LONG_NS = 2000;
  localparam logic [7:0] SHORT_CYC = 8'(SHORT_NS / CLK_NS);
  localparam logic [7:0] LONG_CYC = 8'(LONG_NS / CLK_NS);
  typedef enum logic [1:0] {
    AST_ST_INIT,
    AST_ST_NORMAL,
    AST_ST_WAKE
  } ast_dev_state_t;
endpackage

// ### verilog/ast_sequencer.sv
`timescale 1ns/1ps
module ast_sequencer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [23:0] cmp_out,
  input wire logic [23:0] deglitch_out,
  input wire logic [1:0] dev_state,
  input wire logic fault_state_req,
  input wire logic [1:0] fault_next_state,
  input wire logic reset_request,
  output logic [23:0] cmp_stimulus,
  output logic reset_output_block,
  output logic reset_output,
  output logic state_change_en,
  output logic [1:0] state_change_to,
  output logic fault_state_block,
  output logic supplies_keep_on,
  output logic flag_update_en,
  output logic [23:0] flag_set,
  output logic done_irq,
  output logic wdg_disable,
  output logic errmon_disable
);
  typedef enum logic [1:0] {AST_IDLE, AST_STIM, AST_CHECK, AST_DONE} ast_state_t;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [23:0] ast_legal(input logic measure, input logic depth);
    logic [23:0] m;
    m = measure ? {ast_pkg::INT_MASK2, ast_pkg::INT_MASK1, ast_pkg::INT_MASK0}
                : {ast_pkg::SS_MASK2, ast_pkg::SS_MASK1, ast_pkg::SS_MASK0};
    // Internal supply overvoltage (bank 2 bit 3) cannot take a long stimulus
    if (!measure && depth) begin
      m[ast_pkg::INTERNAL_SUPPLY_OVER_SEL_BIT] = 1'b0;
    end
    return m;
  endfunction

  ast_state_t state, next_state;
  logic [23:0] sel, next_sel;
  logic depth, next_depth, single, next_single, measure, next_measure;
  logic start, next_start, status, next_status;
  logic [4:0] idx, next_idx;
  logic [7:0] tmr, next_tmr;
  logic wdg_off, next_wdg_off, err_off, next_err_off;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_irq;
  logic [23:0] next_stim, next_flag_set;
  logic next_rob, next_rst, next_sce, next_fsb, next_keep, next_flag_en;
  logic [1:0] next_sct;
  logic bus_wr, bus_rd, hit, active, legal;
  logic [23:0] legal_mask;

  assign bus_wr = psel && penable && pwrite;
  assign bus_rd = psel && !penable && !pwrite;
  assign active = start;
  assign legal_mask = ast_legal(measure, depth);
  assign legal = legal_mask[idx];

  // ****************************************************************
  // Sequencer and registers
  // ****************************************************************
  always_comb begin
    next_state = state;
    next_sel = sel;
    next_depth = depth;
    next_single = single;
    next_measure = measure;
    next_start = start;
    next_status = status;
    next_idx = idx;
    next_tmr = tmr;
    next_wdg_off = wdg_off;
    next_err_off = err_off;
    next_irq = 1'b0;
    next_stim = '0;
    next_flag_set = '0;
    next_flag_en = 1'b0;
    if (bus_wr && !start) begin
      case (paddr)
        ast_pkg::ADDR_CTRL: begin
          next_depth = pwdata[ast_pkg::CTRL_DEPTH];
          next_single = pwdata[ast_pkg::CTRL_SINGLE];
          next_measure = pwdata[ast_pkg::CTRL_MEASURE];
          next_start = pwdata[ast_pkg::CTRL_START];
          if (pwdata[ast_pkg::CTRL_START]) begin
            next_status = 1'b0;
            next_idx = '0;
            next_state = AST_STIM;
            next_tmr = '0;
          end
        end
        ast_pkg::ADDR_SEL0: next_sel[7:0] = pwdata[7:0];
        ast_pkg::ADDR_SEL1: next_sel[15:8] = pwdata[7:0];
        ast_pkg::ADDR_SEL2: next_sel[23:16] = pwdata[7:0];
        default: begin
        end
      endcase
    end
    if (bus_wr && paddr == ast_pkg::ADDR_PROT &&
        pwdata[ast_pkg::PROT_KEY_LSB +: 8] == ast_pkg::PROT_KEY) begin
      next_wdg_off = pwdata[ast_pkg::PROT_WDG_OFF];
      next_err_off = pwdata[ast_pkg::PROT_ERR_OFF];
    end
    case (state)
      AST_IDLE: begin
      end
      AST_STIM: begin
        // Fixed order: bank 0 bit 0 upward; skip unselected comparators
        if (!sel[idx] || !legal) begin
          next_state = AST_CHECK;
          next_tmr = '0;
        end else begin
          next_stim[idx] = 1'b1;
          next_tmr = tmr + 8'h01;
          if (tmr + 8'h01 >= (depth ? ast_pkg::LONG_CYC : ast_pkg::SHORT_CYC)) begin
            next_state = AST_CHECK;
          end
        end
      end
      AST_CHECK: begin
        if (sel[idx] && legal) begin
          if (depth ? deglitch_out[idx] : cmp_out[idx]) begin
            next_sel[idx] = 1'b0;
          end
          if (depth) begin
            next_flag_en = 1'b1;
            next_flag_set[idx] = deglitch_out[idx];
          end
        end
        next_tmr = '0;
        if (idx == ast_pkg::NUM_CMP - 5'h01 || (single && sel[idx] && legal)) begin
          next_state = AST_DONE;
        end else begin
          next_idx = idx + 5'h01;
          next_state = AST_STIM;
        end
      end
      AST_DONE: begin
        next_start = 1'b0;
        next_irq = 1'b1;
        next_status = ((sel & ast_legal(measure, depth)) == '0);
        next_state = AST_IDLE;
      end
      default: next_state = AST_IDLE;
    endcase
  end

  // ****************************************************************
  // Bus read and system outputs
  // ****************************************************************
  always_comb begin
    hit = 1'b1;
    next_prdata = '0;
    case (paddr)
      ast_pkg::ADDR_CTRL: begin
        next_prdata[ast_pkg::CTRL_START] = start;
        next_prdata[ast_pkg::CTRL_DEPTH] = depth;
        next_prdata[ast_pkg::CTRL_SINGLE] = single;
        next_prdata[ast_pkg::CTRL_MEASURE] = measure;
        next_prdata[ast_pkg::CTRL_STATUS] = status;
      end
      ast_pkg::ADDR_SEL0: next_prdata[7:0] = sel[7:0];
      ast_pkg::ADDR_SEL1: next_prdata[7:0] = sel[15:8];
      ast_pkg::ADDR_SEL2: next_prdata[7:0] = sel[23:16];
      ast_pkg::ADDR_PROT: next_prdata[1:0] = {err_off, wdg_off};
      ast_pkg::ADDR_MON: next_prdata[1:0] = dev_state;
      default: hit = 1'b0;
    endcase
    if (!bus_rd) begin
      next_prdata = prdata;
    end
    // Single-cycle access: setup registers ready for the access phase
    next_pready = psel && !penable;
    next_pslverr = psel && !penable && !hit;
    next_rob = active;
    next_rst = reset_request && !active;
    next_fsb = active;
    next_keep = active;
    next_sce = fault_state_req && !active;
    next_sct = fault_next_state;
    if (bus_wr && !start && paddr == ast_pkg::ADDR_CTRL && pwdata[ast_pkg::CTRL_START] &&
        !pwdata[ast_pkg::CTRL_MEASURE] &&
        dev_state == ast_pkg::AST_ST_NORMAL) begin
      next_sce = 1'b1;
      next_sct = ast_pkg::AST_ST_WAKE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= AST_IDLE;
      sel <= ast_pkg::SEL_RESET;
      depth <= 1'b0;
      single <= 1'b0;
      measure <= 1'b0;
      start <= 1'b0;
      status <= 1'b0;
      idx <= '0;
      tmr <= '0;
      wdg_off <= 1'b0;
      err_off <= 1'b0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      cmp_stimulus <= '0;
      reset_output_block <= 1'b0;
      reset_output <= 1'b0;
      state_change_en <= 1'b0;
      state_change_to <= ast_pkg::AST_ST_INIT;
      fault_state_block <= 1'b0;
      supplies_keep_on <= 1'b0;
      flag_update_en <= 1'b0;
      flag_set <= '0;
      done_irq <= 1'b0;
      wdg_disable <= 1'b0;
      errmon_disable <= 1'b0;
    end else begin
      state <= next_state;
      sel <= next_sel;
      depth <= next_depth;
      single <= next_single;
      measure <= next_measure;
      start <= next_start;
      status <= next_status;
      idx <= next_idx;
      tmr <= next_tmr;
      wdg_off <= next_wdg_off;
      err_off <= next_err_off;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      cmp_stimulus <= next_stim;
      reset_output_block <= next_rob;
      reset_output <= next_rst;
      state_change_en <= next_sce;
      state_change_to <= next_sct;
      fault_state_block <= next_fsb;
      supplies_keep_on <= next_keep;
      flag_update_en <= next_flag_en;
      flag_set <= next_flag_set;
      done_irq <= next_irq;
      wdg_disable <= next_wdg_off;
      errmon_disable <= next_err_off;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence done_seq;
    state == AST_DONE;
  endsequence
  sequence end_seq;
    !start && done_irq;
  endsequence
  property done_p;
    @(posedge pclk) disable iff (!presetn) done_seq |=> end_seq;
  endproperty
  done_clears_a: assert property (done_p) else $error("start not cleared at end");
  reset_blocked_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(active) |-> !reset_output) else $error("reset during test");
  fault_blocked_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(active) |-> !state_change_en) else $error("fault state change in test");
  supplies_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(active) |-> supplies_keep_on) else $error("supplies not held");
  setup_locked_a: assert property (@(posedge pclk) disable iff (!presetn)
    start && bus_wr && paddr == ast_pkg::ADDR_CTRL |=> $stable(measure) && $stable(depth))
    else $error("config changed in test");
  pass_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == AST_CHECK && sel[idx] && legal && !depth && cmp_out[idx] |=> !sel[$past(idx)])
    else $error("passing bit kept");
  int_supply_skip_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == AST_STIM && depth && !measure |-> !next_stim[ast_pkg::INTERNAL_SUPPLY_OVER_SEL_BIT])
    else $error("internal supply given long stimulus");
  short_stim_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == AST_STIM && !depth |-> tmr < ast_pkg::SHORT_CYC) else $error("stimulus too long");
  status_a: assert property (@(posedge pclk) disable iff (!presetn)
    done_seq |=> status == ((sel & ast_legal(measure, depth)) == '0))
    else $error("status wrong");
  wake_move_a: assert property (@(posedge pclk) disable iff (!presetn)
    bus_wr && !start && paddr == ast_pkg::ADDR_CTRL && pwdata[ast_pkg::CTRL_START] &&
    !pwdata[ast_pkg::CTRL_MEASURE] && dev_state == ast_pkg::AST_ST_NORMAL
    |=> state_change_en && state_change_to == ast_pkg::AST_ST_WAKE)
    else $error("no wake move");
endmodule

// ### verification/ast_cmp_model.sv
`timescale 1ns/1ps
// ****
// Comparator bank model
// ****
module ast_cmp_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [23:0] cmp_stimulus,
  input wire logic [23:0] bad_mask,
  output logic [23:0] cmp_out,
  output logic [23:0] deglitch_out
);
  logic [23:0] prev;
  logic [7:0] cnt;
  // A broken comparator never reports the forced condition
  // Every regulator is enabled, so each healthy comparator responds
  assign cmp_out = cmp_stimulus & ~bad_mask;
  // 20 steady cycles: longer than the short stimulus, shorter than the long one
  assign deglitch_out = (cnt >= 8'h14) ? cmp_out : 24'h000000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev <= 24'h000000;
      cnt <= 8'h00;
    end else begin
      prev <= cmp_stimulus;
      cnt <= (cmp_stimulus != prev || cmp_stimulus == 24'h0) ? 8'h00 : cnt + 8'h01;
    end
  end
endmodule

// ### verification/analog_self_test_sequencer_test.sv
`timescale 1ns/1ps
module analog_self_test_sequencer_test;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'hB7E3C7C6;
  logic pready, pslverr, reset_output_block, reset_output, state_change_en;
  logic fault_state_block, supplies_keep_on, flag_update_en, done_irq;
  logic wdg_disable, errmon_disable, fault_state_req = 1'b0, reset_request = 1'b0;
  logic [1:0] dev_state = 2'h1, fault_next_state = 2'h0, state_change_to;
  logic [23:0] cmp_out, deglitch_out, cmp_stimulus, flag_set, bad_mask = 24'h0;
  logic [23:0] flag_acc = 24'h0;
  logic saw_wake = 1'b0, saw_init = 1'b0;
  logic [32:0] exp_q[$], msk_q[$];
  int bad_count = 0, num_checks = 0;
  always #20 pclk = ~pclk;
  ast_sequencer u_ast_sequencer (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .cmp_out, .deglitch_out, .dev_state,
    .fault_state_req, .fault_next_state, .reset_request, .cmp_stimulus,
    .reset_output_block, .reset_output, .state_change_en, .state_change_to,
    .fault_state_block, .supplies_keep_on, .flag_update_en, .flag_set, .done_irq,
    .wdg_disable, .errmon_disable);
  ast_cmp_model u_ast_cmp_model (.pclk, .presetn, .cmp_stimulus, .bad_mask,
    .cmp_out, .deglitch_out);
  // ****
  // Checking
  // ****
  task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      check("read", {pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());
    end
    if (state_change_en === 1'b1 && state_change_to === 2'h2) saw_wake = 1'b1;
    if (state_change_en === 1'b1 && state_change_to === 2'h0) saw_init = 1'b1;
    if (flag_update_en === 1'b1) flag_acc |= flag_set;
  end
  // ****
  // Stimulus
  // ****
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    apb(a, 1'b0, 32'h0);
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    while (done_irq !== 1'b1 && n < 3000) begin
      @(negedge pclk);
      n++;
    end
    check("done_irq", {32'h0, done_irq}, 33'h1);
  endtask
  initial begin
    int b;
    logic [23:0] r;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(ast_pkg::ADDR_CTRL, 33'h0, 33'h0FFFFFFFF);
    rd(8'h18, 33'h100000000, 33'h100000000);
    rd(ast_pkg::ADDR_MON, 33'h1, 33'h3);
    // Shutdown path, comparator only, one random comparator broken
    b = int'(xs() % 5);
    r = 24'h1 << ((b == 4) ? 5 : b);
    bad_mask <= r;
    apb(ast_pkg::ADDR_SEL0, 1'b1, 32'h2F);
    apb(ast_pkg::ADDR_SEL1, 1'b1, 32'h0E);
    apb(ast_pkg::ADDR_SEL2, 1'b1, 32'hC9);
    apb(ast_pkg::ADDR_CTRL, 1'b1, 32'h01);
    fault_state_req <= 1'b1;
    reset_request <= 1'b1;
    apb(ast_pkg::ADDR_SEL1, 1'b1, 32'hFF);
    apb(ast_pkg::ADDR_CTRL, 1'b1, 32'h0A);
    rd(ast_pkg::ADDR_CTRL, 33'h1, 33'h1);
    @(negedge pclk);
    check("reset_output", {32'h0, reset_output}, 33'h0);
    check("block", {31'h0, reset_output_block, fault_state_block}, 33'h3);
    check("supplies", {32'h0, supplies_keep_on}, 33'h1);
    @(posedge pclk);
    fault_state_req <= 1'b0;
    reset_request <= 1'b0;
    wait_done;
    check("wake_move", {32'h0, saw_wake}, 33'h1);
    check("fault_move", {32'h0, saw_init}, 33'h0);
    rd(ast_pkg::ADDR_SEL0, {25'h0, r[7:0]}, 33'hFF);
    rd(ast_pkg::ADDR_SEL1, 33'h0, 33'hFF);
    rd(ast_pkg::ADDR_SEL2, 33'h0, 33'hFF);
    rd(ast_pkg::ADDR_CTRL, 33'h0, 33'h1F);
    // Interrupt measure including deglitch, all comparators healthy
    bad_mask <= 24'h0;
    dev_state <= 2'h2;
    apb(ast_pkg::ADDR_SEL0, 1'b1, 32'hD0);
    apb(ast_pkg::ADDR_SEL1, 1'b1, 32'hF1);
    apb(ast_pkg::ADDR_SEL2, 1'b1, 32'h30);
    apb(ast_pkg::ADDR_CTRL, 1'b1, 32'h0B);
    wait_done;
    check("flags", {9'h0, flag_acc}, 33'h30F1D0);
    rd(ast_pkg::ADDR_SEL0, 33'h0, 33'hFF);
    rd(ast_pkg::ADDR_SEL1, 33'h0, 33'hFF);
    rd(ast_pkg::ADDR_SEL2, 33'h0, 33'hFF);
    rd(ast_pkg::ADDR_CTRL, 33'h10, 33'h11);
    // Shutdown path with deglitch: internal supply bit is skipped and kept
    apb(ast_pkg::ADDR_SEL0, 1'b1, 32'h01);
    apb(ast_pkg::ADDR_SEL2, 1'b1, 32'h08);
    apb(ast_pkg::ADDR_CTRL, 1'b1, 32'h03);
    wait_done;
    rd(ast_pkg::ADDR_SEL0, 33'h0, 33'hFF);
    rd(ast_pkg::ADDR_SEL2, 33'h08, 33'hFF);
    rd(ast_pkg::ADDR_CTRL, 33'h10, 33'h11);
    // Single comparator: only the first selected one is tested
    apb(ast_pkg::ADDR_SEL0, 1'b1, 32'h03);
    apb(ast_pkg::ADDR_CTRL, 1'b1, 32'h07);
    wait_done;
    rd(ast_pkg::ADDR_SEL0, 33'h02, 33'hFF);
    rd(ast_pkg::ADDR_CTRL, 33'h0, 33'h11);
    // Reset output passes again once idle
    reset_request <= 1'b1;
    repeat (2) @(negedge pclk);
    check("reset_output", {32'h0, reset_output}, 33'h1);
    check("idle", {30'h0, reset_output_block, fault_state_block, supplies_keep_on}, 33'h0);
    @(posedge pclk);
    reset_request <= 1'b0;
    // Protected monitoring switch-off
    r = 24'(xs());
    apb(ast_pkg::ADDR_PROT, 1'b1, 32'h5A03);
    repeat (2) @(negedge pclk);
    check("prot_bad", {31'h0, errmon_disable, wdg_disable}, 33'h0);
    apb(ast_pkg::ADDR_PROT, 1'b1, {16'h0, ast_pkg::PROT_KEY, 6'h0, r[1:0]});
    repeat (2) @(negedge pclk);
    check("prot", {31'h0, errmon_disable, wdg_disable}, {31'h0, r[1:0]});
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    complete_run();
  end
endmodule
